// ---- hss_defines.svh ----
// Timing and width constants for the hot-swap sequencer.
`ifndef HSS_DEFINES_SVH
`define HSS_DEFINES_SVH
`define HSS_CLK_MHZ        25
`define HSS_CFG_GAP_US     128
`define HSS_CFG_GAP_CYC    ((`HSS_CFG_GAP_US * `HSS_CLK_MHZ))
`define HSS_UVOV_FLT_US    1000
`define HSS_UVOV_FLT_CYC   ((`HSS_UVOV_FLT_US * `HSS_CLK_MHZ))
`define HSS_DIS_FLT_US     1000
`define HSS_DIS_FLT_CYC    ((`HSS_DIS_FLT_US * `HSS_CLK_MHZ))
`define HSS_TEMP_FLT_US    12
`define HSS_TEMP_FLT_CYC   ((`HSS_TEMP_FLT_US * `HSS_CLK_MHZ))
`define HSS_OC_FLT_US      100
`define HSS_OC_FLT_CYC     ((`HSS_OC_FLT_US * `HSS_CLK_MHZ))
`define HSS_OC_DWELL_US    3000
`define HSS_OC_DWELL_CYC   ((`HSS_OC_DWELL_US * `HSS_CLK_MHZ))
`define HSS_PG_DLY_US      20000
`define HSS_PG_DLY_CYC     ((`HSS_PG_DLY_US * `HSS_CLK_MHZ))
`define HSS_TMR_DEF_MS     200
`define HSS_TMR_EXT_MS     1000
`define HSS_TMR_DEF_CYC    ((`HSS_TMR_DEF_MS * 1000 * `HSS_CLK_MHZ))
`define HSS_TMR_EXT_CYC    ((`HSS_TMR_EXT_MS * 1000 * `HSS_CLK_MHZ))
`define HSS_RETRY_MAX      4'ha
`define HSS_CNT_W          25
`define HSS_FLT_W          16
`endif

// ---- hss_pkg.sv ----
// Types shared by the hot-swap sequencer files.
package hss_pkg;
  typedef enum logic [2:0] {
    HSS_IDLE, HSS_CFG, HSS_START, HSS_CHARGE, HSS_PGWAIT, HSS_NORMAL, HSS_OVERCUR, HSS_LOCK
  } hss_state_type;
  typedef struct packed {
    logic uv;
    logic ov;
    logic hot;
    logic dis;
    logic oc;
  } hss_flt_type;
  typedef struct packed {
    logic switch_on;
    logic use_oc_limit;
    logic fast_discharge;
    logic pg;
    logic pg_n;
    logic overcurrent;
  } hss_out_type;
endpackage

// ---- hss_filter.sv ----
// Synchroniser and persistence filter for one monitor indication.
`timescale 1ns/1ps
`include "hss_defines.svh"
module hss_filter
  import hss_pkg::*;
#(
  parameter logic [`HSS_FLT_W-1:0] SET_CYC = 16'h0001,
  parameter logic [`HSS_FLT_W-1:0] CLR_CYC = 16'h0001,
  parameter logic                  INIT    = 1'b0
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic raw_in,
  output logic      filt_out
);
  typedef struct packed {
    logic                  s1;
    logic                  s2;
    logic                  f;
    logic [`HSS_FLT_W-1:0] cnt;
  } hss_fst_type;
  hss_fst_type st_q, st_d;
  always_comb begin
    st_d    = st_q;
    st_d.s1 = raw_in;
    st_d.s2 = st_q.s1;
    if (st_q.s2 == st_q.f) begin
      st_d.cnt = '0;
    end else if (st_q.cnt + 16'h0001 >= (st_q.f ? CLR_CYC : SET_CYC)) begin
      st_d.f   = st_q.s2;
      st_d.cnt = '0;
    end else begin
      st_d.cnt = st_q.cnt + 16'h0001;
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '{s1: INIT, s2: INIT, f: INIT, cnt: '0};
    end else begin
      st_q <= st_d;
    end
  end
  assign filt_out = st_q.f;
endmodule

// ---- hss_sequencer.sv ----
// Sequencing and protection state machine of the hot-swap controller.
`timescale 1ns/1ps
`include "hss_defines.svh"
// What this block does
// RULE1: At reset switch is off, both power-good outputs inactive, retry count zero.
// RULE2: Disabled at power-up keeps the block idle, no start sequence; code leaves idle once lockout clears unless disable has persisted 1.0 ms.
// RULE3: After lockout clears, sample limit configs, overvoltage config 128 us later.
// RULE4: Delay-timer configuration input is read continuously, not only at start.
// RULE5: After configuration run start timer and check four start conditions.
// RULE6: Undervoltage or overvoltage faults retry forever without counting retries.
// RULE7: Overtemperature or disable during start interval restarts timer, counts retry.
// RULE8: After ten retries lock out until power cycle or disable clears count.
// RULE9: Charging starts only after conditions held full timer and count at most ten.
// RULE10: Full enhancement switches current limit from charging to overcurrent.
// RULE11: Power-good asserts 20 ms after full enhancement; retry count clears.
// RULE12: Condition violation from enhancement onward turns off and restarts timer.
// RULE13: Overcurrent beyond 100 us enters overcurrent state, regulating at limit.
// RULE14: Overcurrent lasting 3.0 ms turns switch off and restarts sequence.
// RULE15: Overcurrent clearing within dwell returns to normal, power-good kept.
// RULE16: Current above 5 A forces fast discharge and overcurrent state.
// RULE17: Disable held over 1.0 ms turns switch off and power-good off.
// RULE18: Disable released over 1.0 ms starts a new start-up sequence.
// RULE19: Undervoltage and overvoltage count only after persisting 1.0 ms.
// RULE20: Overtemperature acts only after persisting 12 us, dropping power-good.
// RULE21: Active-low power-good is always the complement of active-high.
module hss_sequencer
  import hss_pkg::*;
#(
  parameter logic [`HSS_CNT_W-1:0] START_DEF_CYC = `HSS_CNT_W'(`HSS_TMR_DEF_CYC),
  parameter logic [`HSS_CNT_W-1:0] START_EXT_CYC = `HSS_CNT_W'(`HSS_TMR_EXT_CYC),
  parameter logic [`HSS_CNT_W-1:0] PG_DLY_CYC    = `HSS_CNT_W'(`HSS_PG_DLY_CYC),
  parameter logic [`HSS_CNT_W-1:0] DWELL_CYC     = `HSS_CNT_W'(`HSS_OC_DWELL_CYC),
  parameter logic [`HSS_FLT_W-1:0] UVOV_CYC      = `HSS_FLT_W'(`HSS_UVOV_FLT_CYC),
  parameter logic [`HSS_FLT_W-1:0] DIS_CYC       = `HSS_FLT_W'(`HSS_DIS_FLT_CYC)
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic supply_lockout,
  input  wire logic undervolt_sense,
  input  wire logic overvolt_sense,
  input  wire logic overtemp_sense,
  input  wire logic disable_sense,
  input  wire logic overcurrent_sense,
  input  wire logic short_circuit_sense,
  input  wire logic full_enhance_sense,
  input  wire logic timer_ext_cfg,
  input  wire logic undervolt_cfg,
  input  wire logic overvolt_cfg,
  input  wire logic overcurrent_limit_cfg,
  input  wire logic charge_limit_cfg,
  output logic      switch_on,
  output logic      use_oc_limit,
  output logic      fast_discharge,
  output logic      overcurrent,
  output logic      power_good_out,
  output logic      power_good_n,
  output logic      undervolt_cfg_q,
  output logic      overvolt_cfg_q,
  output logic      oc_limit_cfg_q,
  output logic      charge_cfg_q,
  output logic      locked_out
);
  typedef struct packed {
    hss_state_type         state;
    logic [`HSS_CNT_W-1:0] cnt;
    logic [3:0]            retry;
    logic                  ovc_done;
    logic [3:0]            cfg;
    logic [2:0]            s_lock;
    logic [2:0]            s_cfg;
    logic [1:0]            s_misc;
    logic [1:0]            s_sc;
    hss_out_type           o;
  } hss_st_type;
  hss_st_type st_q, st_d;
  hss_flt_type flt;
  logic start_ok;
  logic [`HSS_CNT_W-1:0] start_cyc;

  // RULE19 voltage filters
  hss_filter #(.SET_CYC(UVOV_CYC), .CLR_CYC(UVOV_CYC), .INIT(1'b1)) u_uv (
    .clk(clk), .sys_rst(sys_rst), .raw_in(undervolt_sense), .filt_out(flt.uv));
  hss_filter #(.SET_CYC(UVOV_CYC), .CLR_CYC(UVOV_CYC), .INIT(1'b0)) u_ov (
    .clk(clk), .sys_rst(sys_rst), .raw_in(overvolt_sense), .filt_out(flt.ov));
  // RULE20 temperature filter
  hss_filter #(.SET_CYC(`HSS_FLT_W'(`HSS_TEMP_FLT_CYC)), .CLR_CYC(16'h0001), .INIT(1'b0)) u_hot (
    .clk(clk), .sys_rst(sys_rst), .raw_in(overtemp_sense), .filt_out(flt.hot));
  // RULE17 disable filter
  hss_filter #(.SET_CYC(DIS_CYC), .CLR_CYC(DIS_CYC), .INIT(1'b0)) u_dis (
    .clk(clk), .sys_rst(sys_rst), .raw_in(disable_sense), .filt_out(flt.dis));
  // RULE13 overcurrent filter
  hss_filter #(.SET_CYC(`HSS_FLT_W'(`HSS_OC_FLT_CYC)), .CLR_CYC(16'h0001), .INIT(1'b0)) u_oc (
    .clk(clk), .sys_rst(sys_rst), .raw_in(overcurrent_sense), .filt_out(flt.oc));

  // RULE5 start conditions
  assign start_ok = !flt.uv && !flt.ov && !flt.hot && !flt.dis;
  // RULE4 live timer select
  assign start_cyc = st_q.s_misc[1] ? START_EXT_CYC : START_DEF_CYC;

  always_comb begin
    st_d        = st_q;
    st_d.s_lock = {st_q.s_lock[1:0], supply_lockout};
    st_d.s_cfg  = {st_q.s_cfg[1:0], 1'b0};
    st_d.s_misc = {st_q.s_misc[0], timer_ext_cfg};
    st_d.s_sc   = {st_q.s_sc[0], short_circuit_sense};
    st_d.s_cfg[0] = full_enhance_sense;
    st_d.o.fast_discharge = 1'b0;
    case (st_q.state)
      HSS_IDLE: begin
        // RULE2 hold while disabled
        if (!st_q.s_lock[2] && !flt.dis) begin
          st_d.state = HSS_CFG;
          st_d.cnt   = '0;
          // RULE3 first config sample
          st_d.cfg[3] = undervolt_cfg;
          st_d.cfg[1] = overcurrent_limit_cfg;
          st_d.cfg[0] = charge_limit_cfg;
        end
      end
      HSS_CFG: begin
        // RULE3 delayed overvoltage sample
        if (st_q.cnt + 25'h1 >= `HSS_CNT_W'(`HSS_CFG_GAP_CYC)) begin
          st_d.cfg[2] = overvolt_cfg;
          st_d.state  = HSS_START;
          st_d.cnt    = '0;
        end else begin
          st_d.cnt = st_q.cnt + 25'h1;
        end
      end
      HSS_START: begin
        if (flt.uv || flt.ov) begin
          // RULE6 unlimited voltage retries
          st_d.cnt = '0;
        end else if (flt.hot || flt.dis) begin
          // RULE7 count retry
          st_d.cnt = '0;
          if (st_q.cnt != '0) begin
            st_d.retry = st_q.retry + 4'h1;
          end
          // RULE8 lockout after ten
          if (st_q.cnt != '0 && st_q.retry >= `HSS_RETRY_MAX) begin
            st_d.state = HSS_LOCK;
          end
        end else if (st_q.cnt + 25'h1 >= start_cyc) begin
          // RULE9 begin charging
          if (st_q.retry <= `HSS_RETRY_MAX) begin
            st_d.state       = HSS_CHARGE;
            st_d.o.switch_on = 1'b1;
          end
          st_d.cnt = '0;
        end else begin
          st_d.cnt = st_q.cnt + 25'h1;
        end
      end
      HSS_CHARGE: begin
        if (st_q.s_cfg[2]) begin
          // RULE10 select overcurrent limit
          st_d.o.use_oc_limit = 1'b1;
          st_d.state          = HSS_PGWAIT;
          st_d.cnt            = '0;
        end
      end
      HSS_PGWAIT: begin
        if (st_q.cnt + 25'h1 >= PG_DLY_CYC) begin
          // RULE11 power-good and retry clear
          st_d.o.pg   = 1'b1;
          st_d.o.pg_n = 1'b0;
          st_d.retry  = '0;
          st_d.state  = HSS_NORMAL;
          st_d.cnt    = '0;
        end else begin
          st_d.cnt = st_q.cnt + 25'h1;
        end
      end
      HSS_NORMAL: begin
        // RULE13 and RULE16 overcurrent entry
        if (flt.oc || st_q.s_sc[1]) begin
          st_d.state         = HSS_OVERCUR;
          st_d.o.overcurrent = 1'b1;
          st_d.o.fast_discharge = st_q.s_sc[1];
          st_d.cnt           = '0;
        end
      end
      HSS_OVERCUR: begin
        st_d.o.fast_discharge = st_q.s_sc[1];
        if (!flt.oc && !st_q.s_sc[1]) begin
          // RULE15 recover with power-good held
          st_d.state         = HSS_NORMAL;
          st_d.o.overcurrent = 1'b0;
        end else if (st_q.cnt + 25'h1 >= DWELL_CYC) begin
          // RULE14 dwell expired
          st_d.ovc_done = 1'b1;
        end else begin
          st_d.cnt = st_q.cnt + 25'h1;
        end
      end
      HSS_LOCK: begin
        // RULE8 disable clears the count
        if (flt.dis) begin
          st_d.retry = '0;
          st_d.state = HSS_START;
          st_d.cnt   = '0;
        end
      end
      default: begin
        st_d.state = HSS_IDLE;
      end
    endcase
    // RULE12 violation after enhancement begins; RULE14 dwell shutdown; RULE17 disable.
    if ((st_q.state == HSS_CHARGE || st_q.state == HSS_PGWAIT || st_q.state == HSS_NORMAL ||
         st_q.state == HSS_OVERCUR) && (!start_ok || st_q.ovc_done)) begin
      st_d.state            = HSS_START;
      st_d.cnt              = '0;
      st_d.ovc_done         = 1'b0;
      st_d.o.switch_on      = 1'b0;
      st_d.o.use_oc_limit   = 1'b0;
      st_d.o.overcurrent    = 1'b0;
      st_d.o.fast_discharge = 1'b0;
      st_d.o.pg             = 1'b0;
      st_d.o.pg_n           = 1'b1;
    end
  end

  // RULE1 reset state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '{state: HSS_IDLE, cnt: '0, retry: '0, ovc_done: 1'b0, cfg: '0,
                s_lock: 3'h7, s_cfg: '0, s_misc: '0, s_sc: '0,
                o: '{switch_on: 1'b0, use_oc_limit: 1'b0, fast_discharge: 1'b0,
                     pg: 1'b0, pg_n: 1'b1, overcurrent: 1'b0}};
    end else begin
      st_q <= st_d;
    end
  end

  assign switch_on       = st_q.o.switch_on;
  assign use_oc_limit    = st_q.o.use_oc_limit;
  assign fast_discharge  = st_q.o.fast_discharge;
  assign overcurrent     = st_q.o.overcurrent;
  assign power_good_out  = st_q.o.pg;
  assign power_good_n    = st_q.o.pg_n;
  assign undervolt_cfg_q = st_q.cfg[3];
  assign overvolt_cfg_q  = st_q.cfg[2];
  assign oc_limit_cfg_q  = st_q.cfg[1];
  assign charge_cfg_q    = st_q.cfg[0];
  assign locked_out      = (st_q.state == HSS_LOCK);

  // RULE21 complement check
  pg_complement_a: assert property (@(posedge clk) disable iff (sys_rst)
    power_good_n == !power_good_out) else $error("power-good outputs not complementary");
  // RULE12 power-good needs switch
  pg_needs_switch_a: assert property (@(posedge clk) disable iff (sys_rst)
    power_good_out |-> switch_on && use_oc_limit) else $error("power-good without switch on");
  // RULE11 power-good timing
  pg_after_enh_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(power_good_out) |-> $past(st_q.state) == HSS_PGWAIT) else $error("power-good not from delay");
  // RULE10 limit change
  limit_change_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(use_oc_limit) |-> $past(st_q.s_cfg[2])) else $error("limit changed without enhancement");
  // RULE9 charge gate
  charge_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(switch_on) |-> $past(st_q.retry) <= `HSS_RETRY_MAX && $past(start_ok)) else $error("bad charge start");
  // RULE17 disable shutdown
  disable_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    flt.dis && switch_on |=> !switch_on && !power_good_out) else $error("switch left on while disabled");
  // RULE8 retry bound
  retry_bound_a: assert property (@(posedge clk) disable iff (sys_rst)
    st_q.retry <= `HSS_RETRY_MAX + 4'h1) else $error("retry count ran past bound");
  // RULE15 overcurrent keeps power-good
  oc_keeps_pg_a: assert property (@(posedge clk) disable iff (sys_rst)
    st_q.state == HSS_OVERCUR && !st_q.ovc_done && start_ok |-> power_good_out) else $error("power-good lost in dwell");
  // RULE11 retry clears at normal
  retry_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(power_good_out) |-> st_q.retry == 4'h0) else $error("retry not cleared");
  reach_normal_c: cover property (@(posedge clk) disable iff (sys_rst) $rose(power_good_out));
  reach_ovc_c: cover property (@(posedge clk) disable iff (sys_rst) $rose(overcurrent));
  reach_lock_c: cover property (@(posedge clk) disable iff (sys_rst) $rose(locked_out));
  ovc_recover_c: cover property (@(posedge clk) disable iff (sys_rst) $fell(overcurrent) && power_good_out);
endmodule

// ---- hss_load_model.sv ----
// Behavioural load and gate model that reports full enhancement of the pass switch.
`timescale 1ns/1ps
module hss_load_model #(
  parameter int CHARGE_CYC = 15
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic switch_on,
  input  wire logic slow,
  output logic      full_enhance_sense
);
  int lim;
  int cnt_q;
  // A big load capacitor charges four times slower, so the bench can stall enhancement.
  assign lim = slow ? 4 * CHARGE_CYC : CHARGE_CYC;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 0;
    end else if (!switch_on) begin
      cnt_q <= 0;
    end else if (cnt_q < lim) begin
      cnt_q <= cnt_q + 1;
    end
  end
  // output near rail.
  // The output only sits at the rail while the switch conducts and the capacitor is full.
  assign full_enhance_sense = switch_on && (cnt_q >= lim);
endmodule

// ---- hss_sequencer_bench.sv ----
// Self-checking testbench of the hot-swap sequencer with a load model.
`timescale 1ns/1ps
module hss_sequencer_bench;
  import hss_pkg::*;
  logic clk, sys_rst, supply_lockout, undervolt_sense, overvolt_sense, overtemp_sense, disable_sense;
  logic overcurrent_sense, short_circuit_sense, full_enhance_sense, timer_ext_cfg, undervolt_cfg;
  logic overvolt_cfg, overcurrent_limit_cfg, charge_limit_cfg, slow;
  logic switch_on, use_oc_limit, fast_discharge, overcurrent, power_good_out, power_good_n;
  logic undervolt_cfg_q, overvolt_cfg_q, oc_limit_cfg_q, charge_cfg_q, locked_out;
  int   fail_count = 0;
  int   checks = 0;
  int   cyc = 0;

  hss_sequencer #(
    .START_DEF_CYC(25'h32), .PG_DLY_CYC(25'h14),
    .DWELL_CYC(25'h1e), .UVOV_CYC(16'h000a), .DIS_CYC(16'h000a)
  ) dut_u (
    .clk, .sys_rst, .supply_lockout, .undervolt_sense, .overvolt_sense, .overtemp_sense, .disable_sense,
    .overcurrent_sense, .short_circuit_sense, .full_enhance_sense, .timer_ext_cfg, .undervolt_cfg,
    .overvolt_cfg, .overcurrent_limit_cfg, .charge_limit_cfg, .switch_on, .use_oc_limit, .fast_discharge,
    .overcurrent, .power_good_out, .power_good_n, .undervolt_cfg_q, .overvolt_cfg_q, .oc_limit_cfg_q,
    .charge_cfg_q, .locked_out
  );
  hss_load_model load_u (.clk, .sys_rst, .switch_on, .slow, .full_enhance_sense);

  task automatic end_sim;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask
  function automatic logic sig(input int i);
    case (i)
      0: return switch_on;
      1: return power_good_out;
      2: return overcurrent;
      3: return locked_out;
      4: return use_oc_limit;
      default: return fast_discharge;
    endcase
  endfunction
  // Waits for an output under a bounded count, then judges it.
  task automatic wait_sig(input string name, input int i, input logic v, input int max);
    int n = 0;
    while (sig(i) !== v && n < max) begin
      @(negedge clk);
      n++;
    end
    chk(name, v, sig(i));
  endtask
  task automatic hold_pg(input int n);
    repeat (n) begin
      @(negedge clk);
      chk("power_good_out", 1'b1, power_good_out);
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      fail_count++;
      $display("[ERR] cycle_limit expected below 80000 seen %0d", cyc);
      end_sim;
    end
  end
  always @(negedge clk) if (!sys_rst) chk("power_good_n", ~power_good_out, power_good_n);

  task automatic t_reset;
    @(negedge clk);
    chk("switch_on", 1'b0, switch_on);
    chk("power_good_out", 1'b0, power_good_out);
    chk("locked_out", 1'b0, locked_out);
    @(posedge clk) supply_lockout <= 1'b0;
    repeat (1000) @(posedge clk);
    overvolt_cfg <= 1'b1;
    repeat (4000) @(negedge clk);
    chk("switch_on", 1'b0, switch_on);
    chk("undervolt_cfg_q", 1'b1, undervolt_cfg_q);
    chk("overvolt_cfg_q", 1'b1, overvolt_cfg_q);
    chk("oc_limit_cfg_q", 1'b1, oc_limit_cfg_q);
    chk("charge_cfg_q", 1'b0, charge_cfg_q);
    $display("test reset done");
  endtask
  task automatic t_walk;
    @(posedge clk) disable_sense <= 1'b0;
    wait_sig("switch_on", 0, 1'b1, 500);
    chk("use_oc_limit", 1'b0, use_oc_limit);
    wait_sig("use_oc_limit", 4, 1'b1, 40);
    repeat (15) @(negedge clk);
    chk("power_good_out", 1'b0, power_good_out);
    wait_sig("power_good_out", 1, 1'b1, 20);
    $display("test power-up done");
  endtask
  task automatic t_short;
    @(posedge clk) short_circuit_sense <= 1'b1;
    wait_sig("fast_discharge", 5, 1'b1, 250);
    wait_sig("overcurrent", 2, 1'b1, 250);
    @(posedge clk) short_circuit_sense <= 1'b0;
    hold_pg(60);
    chk("overcurrent", 1'b0, overcurrent);
    $display("test short circuit done");
  endtask
  task automatic t_dwell;
    @(posedge clk) overcurrent_sense <= 1'b1;
    repeat (2400) @(negedge clk);
    chk("overcurrent", 1'b0, overcurrent);
    wait_sig("overcurrent", 2, 1'b1, 300);
    hold_pg(25);
    wait_sig("power_good_out", 1, 1'b0, 20);
    chk("switch_on", 1'b0, switch_on);
    slow <= 1'b1;
    @(posedge clk) overcurrent_sense <= 1'b0;
    wait_sig("power_good_out", 1, 1'b1, 3000);
    slow <= 1'b0;
    $display("test overcurrent dwell done");
  endtask
  task automatic t_disable;
    @(posedge clk) disable_sense <= 1'b1;
    hold_pg(8);
    wait_sig("power_good_out", 1, 1'b0, 10);
    chk("switch_on", 1'b0, switch_on);
    @(posedge clk) disable_sense <= 1'b0;
    wait_sig("power_good_out", 1, 1'b1, 500);
    $display("test disable done");
  endtask
  task automatic t_volt;
    @(posedge clk) undervolt_sense <= 1'b1;
    repeat (5) @(posedge clk);
    undervolt_sense <= 1'b0;
    hold_pg(20);
    @(posedge clk) overvolt_sense <= 1'b1;
    wait_sig("power_good_out", 1, 1'b0, 25);
    chk("switch_on", 1'b0, switch_on);
    @(posedge clk) overvolt_sense <= 1'b0;
    wait_sig("power_good_out", 1, 1'b1, 500);
    chk("locked_out", 1'b0, locked_out);
    $display("test supply fault done");
  endtask
  task automatic t_hot;
    @(posedge clk) overtemp_sense <= 1'b1;
    hold_pg(290);
    wait_sig("power_good_out", 1, 1'b0, 20);
    @(posedge clk) overtemp_sense <= 1'b0;
    wait_sig("power_good_out", 1, 1'b1, 1500);
    $display("test overtemperature done");
  endtask
  task automatic t_retry;
    @(posedge clk) timer_ext_cfg <= 1'b1;
    repeat (12) begin
      @(posedge clk) overtemp_sense <= 1'b1;
      repeat (400) @(posedge clk);
      overtemp_sense <= 1'b0;
      repeat (600) @(negedge clk);
      chk("switch_on", 1'b0, switch_on);
    end
    wait_sig("locked_out", 3, 1'b1, 500);
    repeat (3000) @(negedge clk);
    chk("switch_on", 1'b0, switch_on);
    @(posedge clk) disable_sense <= 1'b1;
    timer_ext_cfg <= 1'b0;
    repeat (40) @(posedge clk);
    disable_sense <= 1'b0;
    wait_sig("power_good_out", 1, 1'b1, 3000);
    $display("test retry lockout done");
  endtask
  // A second reset in mid-run with new undervoltage, current-limit and charge straps proves those are sampled afresh.
  task automatic t_rerst;
    @(posedge clk) sys_rst <= 1'b1;
    {undervolt_cfg, overvolt_cfg, overcurrent_limit_cfg, charge_limit_cfg} <= 4'h5;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk("power_good_out", 1'b0, power_good_out);
    chk("switch_on", 1'b0, switch_on);
    repeat (3400) @(negedge clk);
    chk("undervolt_cfg_q", 1'b0, undervolt_cfg_q);
    chk("overvolt_cfg_q", 1'b1, overvolt_cfg_q);
    chk("oc_limit_cfg_q", 1'b0, oc_limit_cfg_q);
    chk("charge_cfg_q", 1'b1, charge_cfg_q);
    $display("test second reset done");
  endtask

  initial begin
    {sys_rst, supply_lockout, disable_sense, slow} = 4'he;
    {undervolt_sense, overvolt_sense, overtemp_sense, overcurrent_sense, short_circuit_sense} = 5'h00;
    {timer_ext_cfg, undervolt_cfg, overvolt_cfg, overcurrent_limit_cfg, charge_limit_cfg} = 5'h0a;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset;
    t_walk;
    t_short;
    t_dwell;
    t_disable;
    t_volt;
    t_hot;
    t_retry;
    t_rerst;
    end_sim;
  end
endmodule
